// ===== src/three_level_interrupt_ctrl.sv
// Three-level interrupt controller with AXI4-Lite register access.
// Assumes CPU status pulses and peripheral flags are on aclk.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
module three_level_interrupt_ctrl (
  // Clock and reset
  input  wire  logic                               aclk,
  input  wire  logic                               aresetn,
  // AXI4-Lite write address
  input  wire  logic                               s_axi_awvalid,
  output logic                                     s_axi_awready,
  input  wire  logic [intc_pkg::ADDR_W-1:0]        s_axi_awaddr,
  input  wire  logic [2:0]                         s_axi_awprot,
  // AXI4-Lite write data
  input  wire  logic                               s_axi_wvalid,
  output logic                                     s_axi_wready,
  input  wire  logic [31:0]                        s_axi_wdata,
  input  wire  logic [3:0]                         s_axi_wstrb,
  // AXI4-Lite write response
  output logic                                     s_axi_bvalid,
  input  wire  logic                               s_axi_bready,
  output logic [1:0]                               s_axi_bresp,
  // AXI4-Lite read address
  input  wire  logic                               s_axi_arvalid,
  output logic                                     s_axi_arready,
  input  wire  logic [intc_pkg::ADDR_W-1:0]        s_axi_araddr,
  input  wire  logic [2:0]                         s_axi_arprot,
  // AXI4-Lite read data
  output logic                                     s_axi_rvalid,
  input  wire  logic                               s_axi_rready,
  output logic [31:0]                              s_axi_rdata,
  output logic [1:0]                               s_axi_rresp,
  // Peripheral requests and per-source flags, per vector
  input  wire  logic [intc_pkg::NUM_VEC-1:0]       vec_req,
  input  wire  logic [intc_pkg::NUM_VEC-1:0][7:0]  src_pend,
  // CPU core status
  input  wire  logic                               instr_done,
  input  wire  logic                               return_from_interrupt,
  input  wire  logic                               power_control_register,
  input  wire  logic                               hold_release,
  // CPU core steering
  output logic                                     irq_take,
  output logic [16:0]                              irq_vector
);
  import intc_pkg::*;

  // ==========================================================
  // State
  state_t s_r;
  state_t s_nxt;

  level_t [NUM_VEC-1:0] vec_lvl;
  level_t               cur_lvl;
  level_t               win_lvl;
  logic [3:0]           win_idx;
  logic [7:0]           me_read;
  logic [7:0]           sfl_read;
  logic                 do_wr;
  logic                 wr_ctl;
  logic                 blocked;
  logic                 accept;
  logic                 ret_now;

  // ==========================================================
  // Level of each vector
  always_comb begin
    vec_lvl[0] = s_r.vec_03_level_select ? LVL_LOW : LVL_TOP;
    vec_lvl[1] = s_r.vec_0b_level_select ? LVL_LOW : LVL_TOP;
    for (int i = 2; i < NUM_VEC; i++) begin
      vec_lvl[i] = s_r.vector_level_select[i-2] ?
                   LVL_HIGH : LVL_LOW;
    end
  end

  // ==========================================================
  // Arbitration: scan down so the lowest address wins a tie
  always_comb begin
    win_lvl = LVL_NONE;
    win_idx = 4'h0;
    for (int i = NUM_VEC - 1; i >= 0; i--) begin
      // vec_req is already the merge of a vector's sources
      if (vec_req[i] &&
          (vec_lvl[i] == LVL_TOP || s_r.hl_accept_enable)
          && vec_lvl[i] >= win_lvl) begin
        win_lvl = vec_lvl[i];
        win_idx = 4'(i);
      end
    end
  end

  always_comb begin
    if (s_r.top_level_in_service) begin
      cur_lvl = LVL_TOP;
    end else if (s_r.high_level_in_service) begin
      cur_lvl = LVL_HIGH;
    end else if (s_r.low_level_in_service) begin
      cur_lvl = LVL_LOW;
    end else begin
      cur_lvl = LVL_NONE;
    end
  end

  // ==========================================================
  // Register read images
  always_comb begin
    me_read = {s_r.hl_accept_enable,
               s_r.top_level_in_service,
               s_r.high_level_in_service,
               s_r.low_level_in_service,
               ME_UNUSED_BITS,
               s_r.vec_0b_level_select,
               s_r.vec_03_level_select};
    case (cur_lvl)
      LVL_TOP:  sfl_read = s_r.src_cap[2];
      LVL_HIGH: sfl_read = s_r.src_cap[1];
      LVL_LOW:  sfl_read = s_r.src_cap[0];
      default:  sfl_read = RST_SRC_FLAG_LIST;
    endcase
  end

  // ==========================================================
  // Acceptance and blackout
  always_comb begin
    do_wr   = s_r.aw_got && s_r.w_got && !s_r.bvalid;
    wr_ctl  = do_wr && s_r.wstrb[0] &&
              (s_r.awaddr == ADR_MASTER_ENABLE ||
               s_r.awaddr == ADR_LEVEL_SELECT);
    // Blocking also in the write cycle avoids racing old settings
    blocked = (s_r.blk_cnt != 2'h0) || wr_ctl || hold_release;
    ret_now = instr_done && return_from_interrupt;
    accept  = instr_done && !blocked &&
              !power_control_register &&
              !return_from_interrupt &&
              win_lvl > cur_lvl;
  end

  // ==========================================================
  // Next state
  always_comb begin
    s_nxt      = s_r;
    s_nxt.take = 1'b0;

    // Blackout counter
    if (wr_ctl || hold_release) begin
      s_nxt.blk_cnt = BLACKOUT_CYC;
    end else if (s_r.blk_cnt != 2'h0) begin
      s_nxt.blk_cnt = s_r.blk_cnt - 2'h1;
    end

    // Accept: flag the level, freeze source list, steer the core
    if (accept) begin
      s_nxt.take     = 1'b1;
      s_nxt.vec_addr = VEC_ADDR[win_idx];
      case (win_lvl)
        LVL_TOP: begin
          s_nxt.top_level_in_service = 1'b1;
          s_nxt.src_cap[2] = src_pend[win_idx] |
                             ~SRC_ASSIGNED[win_idx];
        end
        LVL_HIGH: begin
          s_nxt.high_level_in_service = 1'b1;
          s_nxt.src_cap[1] = src_pend[win_idx] |
                             ~SRC_ASSIGNED[win_idx];
        end
        default: begin
          s_nxt.low_level_in_service = 1'b1;
          s_nxt.src_cap[0] = src_pend[win_idx] |
                             ~SRC_ASSIGNED[win_idx];
        end
      endcase
    end else if (ret_now) begin
      // Drop only the active level so the outer one resumes
      case (cur_lvl)
        LVL_TOP:  s_nxt.top_level_in_service  = 1'b0;
        LVL_HIGH: s_nxt.high_level_in_service = 1'b0;
        LVL_LOW:  s_nxt.low_level_in_service  = 1'b0;
        default:  s_nxt.low_level_in_service  = 1'b0;
      endcase
    end

    // Write channels are taken independently, in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
    end
    if (do_wr) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got  = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = RESP_OKAY;
      case (s_r.awaddr)
        ADR_MASTER_ENABLE: begin
          if (s_r.wstrb[0]) begin
            // In-service bits are never taken from software
            s_nxt.hl_accept_enable    = s_r.wdata[POS_HL_ENABLE];
            s_nxt.vec_0b_level_select = s_r.wdata[POS_VEC_0B_SEL];
            s_nxt.vec_03_level_select = s_r.wdata[POS_VEC_03_SEL];
          end
        end
        ADR_LEVEL_SELECT: begin
          if (s_r.wstrb[0]) begin
            s_nxt.vector_level_select = s_r.wdata[7:0];
          end
        end
        ADR_SRC_FLAG_LIST: s_nxt.bresp = RESP_OKAY;
        default:           s_nxt.bresp = RESP_SLVERR;
      endcase
    end else if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end

    // Read channel
    if (s_axi_arvalid && s_axi_arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = RESP_OKAY;
      case (s_axi_araddr)
        ADR_SRC_FLAG_LIST: s_nxt.rdata = {24'h000000, sfl_read};
        ADR_MASTER_ENABLE: s_nxt.rdata = {24'h000000, me_read};
        ADR_LEVEL_SELECT:  s_nxt.rdata =
          {24'h000000, s_r.vector_level_select};
        default: begin
          s_nxt.rdata = 32'h00000000;
          s_nxt.rresp = RESP_SLVERR;
        end
      endcase
    end else if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r                       <= '0;
      s_r.hl_accept_enable      <= RST_HL_ENABLE;
      s_r.vec_0b_level_select   <= RST_VEC_SEL[1];
      s_r.vec_03_level_select   <= RST_VEC_SEL[0];
      s_r.vector_level_select   <= RST_LEVEL_SELECT;
      s_r.src_cap               <= {3{RST_SRC_FLAG_LIST}};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
  assign s_axi_wready  = !s_r.w_got && !s_r.bvalid;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_rvalid  = s_r.rvalid;
  assign s_axi_rdata   = s_r.rdata;
  assign s_axi_rresp   = s_r.rresp;
  assign irq_take      = s_r.take;
  assign irq_vector    = s_r.vec_addr;

endmodule : three_level_interrupt_ctrl

// ===== src/intc_pkg.sv
// Constants, register map and state record for the three-level
// interrupt controller. Assumes a 20 MHz cycle clock and AXI4-Lite.
package intc_pkg;

  // ==========================================================
  // Register map (printed offsets are indices, byte = 4 x index)
  localparam int           ADDR_W            = 18;
  localparam logic [15:0]  IDX_SRC_FLAG_LIST = 16'hFE05;
  localparam logic [15:0]  IDX_MASTER_ENABLE = 16'hFE08;
  localparam logic [15:0]  IDX_LEVEL_SELECT  = 16'hFE09;
  localparam logic [ADDR_W-1:0] ADR_SRC_FLAG_LIST =
    {IDX_SRC_FLAG_LIST, 2'b00};
  localparam logic [ADDR_W-1:0] ADR_MASTER_ENABLE =
    {IDX_MASTER_ENABLE, 2'b00};
  localparam logic [ADDR_W-1:0] ADR_LEVEL_SELECT  =
    {IDX_LEVEL_SELECT, 2'b00};

  // ==========================================================
  // Field positions and reset values
  localparam int          POS_HL_ENABLE     = 7;
  localparam int          POS_TOP_INSVC     = 6;
  localparam int          POS_HIGH_INSVC    = 5;
  localparam int          POS_LOW_INSVC     = 4;
  localparam int          POS_VEC_0B_SEL    = 1;
  localparam int          POS_VEC_03_SEL    = 0;
  localparam logic [1:0]  ME_UNUSED_BITS    = 2'h3;
  localparam logic [7:0]  RST_SRC_FLAG_LIST = 8'hFF;
  localparam logic [7:0]  RST_LEVEL_SELECT  = 8'h00;
  localparam logic        RST_HL_ENABLE     = 1'h0;
  localparam logic [1:0]  RST_VEC_SEL       = 2'h0;

  // ==========================================================
  // AXI responses
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;

  // ==========================================================
  // Timing: blackout after control writes or leaving HOLD
  localparam int          CYC_NS            = 50;
  localparam int          BLACKOUT_NS       = 100;
  localparam logic [1:0]  BLACKOUT_CYC      =
    2'((BLACKOUT_NS + CYC_NS - 1) / CYC_NS);

  // ==========================================================
  // Levels, vectors and source bit layout
  localparam int          NUM_VEC           = 10;
  typedef enum logic [1:0] {
    LVL_NONE = 2'b00,
    LVL_LOW  = 2'b01,
    LVL_HIGH = 2'b10,
    LVL_TOP  = 2'b11
  } level_t;
  localparam logic [NUM_VEC-1:0][16:0] VEC_ADDR = {
    17'h0004B, 17'h00043, 17'h0003B, 17'h00033, 17'h0002B,
    17'h00023, 17'h0001B, 17'h00013, 17'h0000B, 17'h00003};
  localparam logic [NUM_VEC-1:0][7:0] SRC_ASSIGNED = {
    8'h3C, 8'hDC, 8'h34, 8'h1C, 8'h0C,
    8'h04, 8'h7C, 8'h1C, 8'h04, 8'h04};

  // ==========================================================
  // Whole state of the controller
  typedef struct packed {
    logic              hl_accept_enable;
    logic              vec_0b_level_select;
    logic              vec_03_level_select;
    logic [7:0]        vector_level_select;
    logic              top_level_in_service;
    logic              high_level_in_service;
    logic              low_level_in_service;
    logic [2:0][7:0]   src_cap;
    logic [1:0]        blk_cnt;
    logic              take;
    logic [16:0]       vec_addr;
    logic              aw_got;
    logic [ADDR_W-1:0] awaddr;
    logic              w_got;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } state_t;

endpackage : intc_pkg

// ===== dv/intc_chk.sv
// Concurrent checks on the interrupt controller's top-level ports.
// Assumes a single aclk domain with synchronous active-low aresetn.
module intc_chk (
  // Clock and reset
  input wire logic                         aclk,
  input wire logic                         aresetn,
  // Bus handshakes
  input wire logic                         s_axi_bvalid,
  input wire logic                         s_axi_bready,
  input wire logic                         s_axi_arvalid,
  input wire logic                         s_axi_arready,
  input wire logic                         s_axi_rvalid,
  // CPU side
  input wire logic [intc_pkg::NUM_VEC-1:0] vec_req,
  input wire logic                         instr_done,
  input wire logic                         return_from_interrupt,
  input wire logic                         power_control_register,
  input wire logic                         hold_release,
  input wire logic                         irq_take,
  input wire logic [16:0]                  irq_vector
);
  timeunit 1ns;
  timeprecision 1ns;
  import intc_pkg::*;
  // ==========
  // Request seen at the deciding edge
  logic [NUM_VEC-1:0] req_r;
  always_ff @(posedge aclk) req_r <= vec_req;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========
  // Acceptance
  chk_only_boundary: assert property (!instr_done |=> !irq_take)
    else $error("accept away from an instruction boundary");
  chk_take_req: assert property (irq_take |-> req_r[irq_vector[6:3]])
    else $error("accepted vector was not requesting");
  chk_vec_legal: assert property (irq_take |->
    irq_vector[2:0] == 3'h3 && irq_vector <= 17'h0004B)
    else $error("accepted vector outside the table");
  chk_vec_hold: assert property (!irq_take |-> $stable(irq_vector))
    else $error("vector changed without an accept");
  // ==========
  // Blackouts
  chk_ret_quiet: assert property (
    instr_done && return_from_interrupt |=> !irq_take)
    else $error("accept on a return boundary");
  chk_pwr_quiet: assert property (
    instr_done && power_control_register |=> !irq_take)
    else $error("accept after power control write");
  chk_hold_quiet: assert property (hold_release |=> !irq_take [*2])
    else $error("accept too soon after leaving hold");
  // ==========
  // Bus answers
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  cov_take: cover property (irq_take);
  cov_ret: cover property (instr_done && return_from_interrupt);
  cov_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule : intc_chk

bind three_level_interrupt_ctrl intc_chk u_chk (.aclk, .aresetn,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .vec_req, .instr_done, .return_from_interrupt,
  .power_control_register, .hold_release, .irq_take, .irq_vector);

// ===== dv/src_model.sv
// Peripheral request sources standing in front of the controller.
// Assumes flag and enable words are driven by the bench on aclk.
module src_model (
  // Source flags and enables, per vector
  input  wire logic [intc_pkg::NUM_VEC-1:0][7:0] src_flag,
  input  wire logic [intc_pkg::NUM_VEC-1:0][7:0] src_en,
  // Merged requests and flags
  output logic      [intc_pkg::NUM_VEC-1:0]      vec_req,
  output logic      [intc_pkg::NUM_VEC-1:0][7:0] src_pend
);
  timeunit 1ns;
  timeprecision 1ns;
  import intc_pkg::*;
  // ==========
  // Unassigned positions never request
  always_comb begin
    for (int i = 0; i < NUM_VEC; i++) begin
      src_pend[i] = src_flag[i] & src_en[i] & SRC_ASSIGNED[i];
      vec_req[i]  = |src_pend[i];
    end
  end
endmodule : src_model

// ===== dv/tb_three_level_interrupt_ctrl.sv
// Self-checking bench for the three-level interrupt controller.
// Assumes the source model and the bound checker are compiled too.
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb_three_level_interrupt_ctrl import intc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic                    aclk, aresetn, awvalid, awready, wvalid;
  logic                    wready, bvalid, bready, arvalid, arready;
  logic                    rvalid, rready, take, instr_done;
  logic                    ret_i, pwr_i, hold_i;
  logic [ADDR_W-1:0]       awaddr, araddr;
  logic [31:0]             wdata, rdata;
  logic [3:0]              wstrb, isv;
  logic [1:0]              bresp, rresp;
  logic [16:0]             vec;
  logic [NUM_VEC-1:0]      vreq;
  logic [NUM_VEC-1:0][7:0] pend, flag, en;
  int                      n_fail, checks, seed;
  logic [7:0]              cap_e [4];
  initial begin
    aclk = 1'h0;
    forever #25 aclk = ~aclk;
  end
  src_model pm (.src_flag(flag), .src_en(en), .vec_req(vreq),
    .src_pend(pend));
  three_level_interrupt_ctrl uut (.aclk, .aresetn,
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .vec_req(vreq), .src_pend(pend), .instr_done(instr_done),
    .return_from_interrupt(ret_i), .power_control_register(pwr_i),
    .hold_release(hold_i), .irq_take(take), .irq_vector(vec));
  // ==========
  // Expectation model
  function automatic int lvl(int i, logic [7:0] me, logic [7:0] ls);
    if (i < 2) return me[i] ? 1 : 3;
    return ls[i-2] ? 2 : 1;
  endfunction : lvl
  function automatic int act();
    return isv[3] ? 3 : isv[2] ? 2 : isv[1] ? 1 : 0;
  endfunction : act
  function automatic int win(logic [9:0] q, logic [7:0] me, ls);
    int b, bl, l;
    b = -1;
    bl = act();
    for (int i = 0; i < NUM_VEC; i++) begin
      l = lvl(i, me, ls);
      if (q[i] && l > bl && (me[7] || l == 3)) begin
        b = i;
        bl = l;
      end
    end
    return b;
  endfunction : win
  // ==========
  // Drivers
  task automatic step(input logic r, p, e, input logic [16:0] v);
    @(posedge aclk);
    instr_done <= 1'h1;
    ret_i      <= r;
    pwr_i      <= p;
    hold_i     <= 1'h0;
    @(posedge aclk);
    instr_done <= 1'h0;
    #1;
    `CHK(take, e)
    if (e) `CHK(vec, v)
  endtask : step
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic       ha, hw, hb;
    logic [1:0] cr;
    @(posedge aclk);
    {awvalid, wvalid, bready} <= 3'h7;
    awaddr <= a;
    wdata  <= {24'h0, d};
    hb = 1'h0;
    while (!hb) begin
      @(negedge aclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid && bready;
      cr = bresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'h0;
      if (hw) wvalid <= 1'h0;
    end
    bready <= 1'h0;
    `CHK(cr, RESP_OKAY)
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] d,
                    input logic [1:0] r);
    logic        ha, hr;
    logic [31:0] cd;
    logic [1:0]  cr;
    @(posedge aclk);
    {arvalid, rready} <= 2'h3;
    araddr <= a;
    hr = 1'h0;
    while (!hr) begin
      @(negedge aclk);
      ha = arvalid && arready;
      hr = rvalid && rready;
      cd = rdata;
      cr = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 1'h0;
    end
    rready <= 1'h0;
    `CHK(cd, {24'h0, d})
    `CHK(cr, r)
  endtask : rd
  task automatic print_verdict();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  // ==========
  // Watchdog, far beyond the expected run of about a thousand cycles
  initial begin
    repeat (40000) @(posedge aclk);
    n_fail++;
    print_verdict();
  end
  // ==========
  // Main sequence
  initial begin
    int         w, l;
    logic [7:0] me, ls;
    seed = 32'hC2AC;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {instr_done, ret_i, pwr_i, hold_i} = 4'h0;
    {awaddr, araddr, wdata, flag, en, isv} = '0;
    wstrb = 4'hF;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    rd(ADR_MASTER_ENABLE, 8'h0C, RESP_OKAY);
    rd(ADR_LEVEL_SELECT, RST_LEVEL_SELECT, RESP_OKAY);
    rd(ADR_SRC_FLAG_LIST, RST_SRC_FLAG_LIST, RESP_OKAY);
    rd(18'h00010, 8'h00, RESP_SLVERR);
    wr(ADR_SRC_FLAG_LIST, 8'h00);
    wr(ADR_MASTER_ENABLE, 8'h7F);
    rd(ADR_MASTER_ENABLE, 8'h0F, RESP_OKAY);
    @(posedge aclk);
    flag[0] <= 8'h04;
    en[0]   <= 8'hFF;
    // Request already pending when the level flips to top
    fork
      wr(ADR_MASTER_ENABLE, 8'h00);
      begin
        repeat (2) @(posedge aclk);
        step(1'h0, 1'h0, 1'h0, 17'h0);
      end
    join
    step(1'h0, 1'h0, 1'h1, VEC_ADDR[0]);
    step(1'h1, 1'h0, 1'h0, 17'h0);
    rd(ADR_MASTER_ENABLE, 8'h0C, RESP_OKAY);
    @(posedge aclk);
    hold_i <= 1'h1;
    step(1'h0, 1'h0, 1'h0, 17'h0);
    step(1'h0, 1'h0, 1'h1, VEC_ADDR[0]);
    step(1'h1, 1'h0, 1'h0, 17'h0);
    step(1'h0, 1'h1, 1'h0, 17'h0);
    step(1'h0, 1'h0, 1'h1, VEC_ADDR[0]);
    step(1'h1, 1'h0, 1'h0, 17'h0);
    repeat (24) begin
      me = 8'($random(seed));
      ls = 8'($random(seed));
      @(posedge aclk);
      for (int i = 0; i < NUM_VEC; i++) begin
        flag[i] <= 8'($random(seed));
        en[i]   <= ($random(seed) % 3 == 0) ? 8'hFF : 8'h00;
      end
      wr(ADR_MASTER_ENABLE, me);
      wr(ADR_LEVEL_SELECT, ls);
      repeat (3) @(posedge aclk);
      repeat (2) begin
        w = win(vreq, me, ls);
        l = (w < 0) ? 0 : lvl(w, me, ls);
        step(1'h0, 1'h0, w >= 0, VEC_ADDR[(w < 0) ? 0 : w]);
        if (w >= 0) begin
          isv[l] = 1'h1;
          cap_e[l] = pend[w] | ~SRC_ASSIGNED[w];
          rd(ADR_SRC_FLAG_LIST, cap_e[l], 2'h0);
        end
        // New flags so a higher level can nest on the next pass
        @(posedge aclk);
        for (int i = 0; i < NUM_VEC; i++) begin
          flag[i] <= 8'($random(seed));
        end
        @(posedge aclk);
      end
      rd(ADR_MASTER_ENABLE, {me[7], isv[3:1], 2'h3, me[1:0]}, 2'h0);
      while (act() > 0) begin
        step(1'h1, 1'h0, 1'h0, 17'h0);
        isv[act()] = 1'h0;
        l = act();
        rd(ADR_SRC_FLAG_LIST, (l > 0) ? cap_e[l] : 8'hFF, 2'h0);
      end
    end
    print_verdict();
  end
endmodule : tb_three_level_interrupt_ctrl
